/* inc/esr_consts.vh */
/*
 * Constants for the serial EEPROM port recovery and protection logic.
 * Assumes a 10 MHz core clock; all times are turned into cycles here.
 */
// What the document requires
// RL1: Controller resets port: start, nine clocks, start.
// RL2: Controller releases data during dummy clocks.
// RL3: Device may drive ack or data then.
// RL4: Reset sequence ignored during internal write.
// RL5: Power-on reset blocks array writes.
// RL6: Controller holds data high at power rise.
// RL7: Controller keeps lines from floating at power-up.
// RL8: Low data at power-up: drive both high.
// RL9: Floated lines at power-up: run software reset.
// RL10: Both faults: lines high, then software reset.
// RL11: Pulses of 100ns or less filtered out.
// RL12: Write-protect high refuses array writes.
// RL13: Controller holds write-protect start through stop.
// RL14: No write cycle start at low supply.
// RL15: Start is data fall with clock high.
// RL16: Reads unaffected by write-protect.
// RL17: No ack to write address while busy.
// RL18: Address counter cleared at power-on.
// RL19: Software reset abandons partial command.
// RL20: Write-protect high anytime in transfer suppresses write.
`ifndef ESR_CONSTS_VH
`define ESR_CONSTS_VH

`define ESR_CLK_MHZ     10
`define ESR_FILT_NS     100
`define ESR_FILT_CYC    ((`ESR_FILT_NS * `ESR_CLK_MHZ) / 1000 + 1)
`define ESR_POR_NS      100000
`define ESR_POR_CYC     ((`ESR_POR_NS * `ESR_CLK_MHZ) / 1000)
`define ESR_WC_CYC      50000
`define ESR_DEV_CODE    4'ha
`define ESR_BIT_ACK     4'h8
`define ESR_BIT_LAST    4'h7
`define ESR_PAGE_MSB    7
`define ESR_ADDR_RST    16'h0000

`endif

/* hw/esr_glitch_filter.v */
/*
 * Two-flop synchroniser and pulse filter for one pin.
 * Assumes the pin is asynchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "esr_consts.vh"

module esr_glitch_filter (
	// Clock and reset
	input  wire       core_clk,
	input  wire       rst_b,
	input  wire       ce,
	// Pin and clean level
	input  wire       pin,
	output reg        level
);

	reg        sync1;
	reg        sync2;
	reg  [2:0] cnt;

	localparam integer FILT_LAST = `ESR_FILT_CYC - 1;

	// Level only follows after the change has held FILT_CYC samples
	always @(posedge core_clk) begin
		if (!rst_b) begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
			cnt   <= 3'h0;
			level <= 1'b1;
		end else if (ce) begin
			sync1 <= pin;
			sync2 <= sync1;
			if (sync2 == level) begin
				cnt <= 3'h0;
			end else if ({29'h0, cnt} == FILT_LAST) begin
				cnt   <= 3'h0;
				level <= sync2; // [RL11]
			end else begin
				cnt <= cnt + 3'h1;
			end
		end
	end

endmodule
`default_nettype wire

/* hw/esr_port.v */
/*
 * Serial EEPROM two-wire port: start/stop detection, address and data
 * byte engine, software reset recovery, write-protect and supply gating,
 * power-on write blocking and internal write cycle timing.
 * Assumes the memory array sits outside, reads combinationally at
 * rd_addr and takes wdat bytes into a page buffer committed by wr_commit.
 */
`timescale 1ns/1ps
`default_nettype none
`include "esr_consts.vh"

module esr_port #(
	parameter WC_CYCLES = `ESR_WC_CYC
) (
	// Clock and reset
	input  wire        core_clk,
	input  wire        rst_b,
	input  wire        ce,
	// Serial pins
	input  wire        scl_in,
	input  wire        sda_in,
	output reg         sda_out,
	output reg         sda_oe_b,
	// Straps, protection and supply monitor
	input  wire [2:0]  strap_in,
	input  wire        wp_in,
	input  wire        supply_low_in,
	// Memory array side
	output reg  [15:0] rd_addr,
	input  wire [7:0]  rd_data,
	output reg         wdat_valid,
	output reg  [15:0] wdat_addr,
	output reg  [7:0]  wdat,
	output reg         wr_commit,
	output reg         wr_abort,
	output reg         wr_busy,
	output reg         por_busy
);

	// ****************************************
	// States
	// ****************************************
	localparam [5:0] ST_IDLE  = 6'h01;
	localparam [5:0] ST_DEV   = 6'h02;
	localparam [5:0] ST_ADRHI = 6'h04;
	localparam [5:0] ST_ADRLO = 6'h08;
	localparam [5:0] ST_WDATA = 6'h10;
	localparam [5:0] ST_RDATA = 6'h20;

	wire        scl_f;
	wire        sda_f;
	reg         scl_d;
	reg         sda_d;
	reg  [2:0]  strap_s1;
	reg  [2:0]  strap_s;
	reg         wp_s1;
	reg         wp_s;
	reg         low_s1;
	reg         low_s;
	reg  [5:0]  state;
	reg  [3:0]  bit_cnt;
	reg  [7:0]  shreg;
	reg  [7:0]  out_byte;
	reg  [7:0]  addr_hi;
	reg         rd_dir;
	reg         acking;
	reg         mst_ack;
	reg         got_data;
	reg         wp_seen;
	reg  [15:0] por_cnt;
	reg  [15:0] wc_cnt;
	reg         dev_match;
	reg         write_ok;
	reg         seen_rise;
	wire [3:0]  tx_idx = `ESR_BIT_LAST - 4'h1 - bit_cnt;

	localparam integer POR_LAST = `ESR_POR_CYC - 1;
	localparam integer WC_LAST  = WC_CYCLES - 1;

	esr_glitch_filter u_scl_filt (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.ce       (ce),
		.pin      (scl_in),
		.level    (scl_f)
	);

	esr_glitch_filter u_sda_filt (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.ce       (ce),
		.pin      (sda_in),
		.level    (sda_f)
	);

	// ****************************************
	// Bus events
	// ****************************************
	wire scl_rise = scl_f & ~scl_d;
	wire scl_fall = ~scl_f & scl_d;
	wire start_ev = scl_f & scl_d & sda_d & ~sda_f; // [RL15]
	wire stop_ev  = scl_f & scl_d & ~sda_d & sda_f;

	always @* begin
		dev_match = (shreg[7:4] == `ESR_DEV_CODE) && (shreg[3:1] == strap_s);
		// Any one of these vetoes the internal write cycle
		write_ok  = ~wp_seen & ~low_s & ~por_busy & ~wr_busy; // [RL12] [RL14] [RL5]
	end

	// ****************************************
	// Synchronisers and power-on block
	// ****************************************
	always @(posedge core_clk) begin
		if (!rst_b) begin
			scl_d    <= 1'b1;
			sda_d    <= 1'b1;
			strap_s1 <= 3'h0;
			strap_s  <= 3'h0;
			wp_s1    <= 1'b1;
			wp_s     <= 1'b1;
			low_s1   <= 1'b1;
			low_s    <= 1'b1;
			por_cnt  <= 16'h0000;
			por_busy <= 1'b1;
		end else if (ce) begin
			scl_d    <= scl_f;
			sda_d    <= sda_f;
			strap_s1 <= strap_in;
			strap_s  <= strap_s1;
			wp_s1    <= wp_in;
			wp_s     <= wp_s1;
			low_s1   <= supply_low_in;
			low_s    <= low_s1;
			// Writes stay blocked until the supply has had time to settle
			if ({16'h0000, por_cnt} == POR_LAST) begin
				por_busy <= 1'b0; // [RL5]
			end else begin
				por_cnt <= por_cnt + 16'h0001;
			end
		end
	end

	// ****************************************
	// Internal write cycle timer
	// ****************************************
	always @(posedge core_clk) begin
		if (!rst_b) begin
			wc_cnt  <= 16'h0000;
			wr_busy <= 1'b0;
		end else if (ce) begin
			if (wr_commit) begin
				wr_busy <= 1'b1;
				wc_cnt  <= 16'h0000;
			end else if (wr_busy) begin
				if ({16'h0000, wc_cnt} == WC_LAST) begin
					wr_busy <= 1'b0;
				end else begin
					wc_cnt <= wc_cnt + 16'h0001;
				end
			end
		end
	end

	// ****************************************
	// Byte engine
	// ****************************************
	always @(posedge core_clk) begin
		if (!rst_b) begin
			state      <= ST_IDLE;
			bit_cnt    <= 4'h0;
			shreg      <= 8'h00;
			out_byte   <= 8'h00;
			addr_hi    <= 8'h00;
			rd_dir     <= 1'b0;
			acking     <= 1'b0;
			mst_ack    <= 1'b0;
			got_data   <= 1'b0;
			seen_rise  <= 1'b0;
			wp_seen    <= 1'b0;
			rd_addr    <= `ESR_ADDR_RST; // [RL18]
			sda_out    <= 1'b0;
			sda_oe_b   <= 1'b1;
			wdat_valid <= 1'b0;
			wdat_addr  <= 16'h0000;
			wdat       <= 8'h00;
			wr_commit  <= 1'b0;
			wr_abort   <= 1'b0;
		end else if (ce) begin
			wdat_valid <= 1'b0;
			wr_commit  <= 1'b0;
			wr_abort   <= 1'b0;
			// Protect level is watched over the whole transfer, not sampled once
			if (start_ev) begin
				wp_seen <= wp_s; // [RL20]
			end else if (wp_s) begin
				wp_seen <= 1'b1; // [RL20]
			end
			if (start_ev) begin
				// A start drops whatever was half received; this is what
				// makes start + nine clocks + start a port reset
				state    <= ST_DEV; // [RL19] [RL1]
				bit_cnt  <= 4'h0;
				got_data <= 1'b0;
				seen_rise <= 1'b0;
				sda_oe_b <= 1'b1;
			end else if (stop_ev) begin
				state    <= ST_IDLE;
				sda_oe_b <= 1'b1;
				if (state == ST_WDATA && got_data && !wr_busy) begin
					if (write_ok) begin
						wr_commit <= 1'b1;
					end else begin
						wr_abort <= 1'b1; // [RL12] [RL14]
					end
				end
			end else if (state != ST_IDLE) begin
				if (scl_rise) begin
					seen_rise <= 1'b1;
					if (bit_cnt < `ESR_BIT_ACK) begin
						shreg <= {shreg[6:0], sda_f};
					end else begin
						mst_ack <= ~sda_f;
					end
				end
				// The clock fall that closes a start carries no bit
				if (scl_fall && seen_rise) begin
					if (bit_cnt < `ESR_BIT_LAST) begin
						bit_cnt <= bit_cnt + 4'h1;
						if (state == ST_RDATA) begin
							sda_oe_b <= out_byte[tx_idx[2:0]];
						end
					end else if (bit_cnt == `ESR_BIT_LAST) begin
						bit_cnt <= `ESR_BIT_ACK;
						case (state)
							ST_DEV: begin
								// Busy part stays silent so polling sees a nack
								acking <= dev_match & ~wr_busy; // [RL17] [RL4]
								rd_dir <= shreg[0];
								sda_oe_b <= ~(dev_match & ~wr_busy); // [RL3]
							end
							ST_RDATA: begin
								acking   <= 1'b0;
								sda_oe_b <= 1'b1;
							end
							default: begin
								acking   <= 1'b1;
								sda_oe_b <= 1'b0;
							end
						endcase
					end else begin
						bit_cnt  <= 4'h0;
						sda_oe_b <= 1'b1;
						case (state)
							ST_DEV: begin
								if (!acking) begin
									state <= ST_IDLE;
								end else if (rd_dir) begin
									// Reads ignore write-protect entirely
									state    <= ST_RDATA; // [RL16]
									out_byte <= rd_data;
									sda_oe_b <= rd_data[7];
									rd_addr  <= rd_addr + 16'h0001;
								end else begin
									state <= ST_ADRHI;
								end
							end
							ST_ADRHI: begin
								addr_hi <= shreg;
								state   <= ST_ADRLO;
							end
							ST_ADRLO: begin
								rd_addr <= {addr_hi, shreg};
								state   <= ST_WDATA;
							end
							ST_WDATA: begin
								got_data   <= 1'b1;
								wdat_valid <= 1'b1;
								wdat_addr  <= rd_addr;
								wdat       <= shreg;
								// Page write wraps inside the 128-byte page
								rd_addr <= {rd_addr[15:`ESR_PAGE_MSB],
									rd_addr[`ESR_PAGE_MSB-1:0] + 7'h01};
							end
							ST_RDATA: begin
								if (mst_ack) begin
									out_byte <= rd_data;
									sda_oe_b <= rd_data[7];
									rd_addr  <= rd_addr + 16'h0001;
								end else begin
									state <= ST_IDLE;
								end
							end
							default: begin
								state <= ST_IDLE;
							end
						endcase
					end
				end
			end
		end
	end

endmodule
`default_nettype wire

/* tb/esr_checker.sv */
/* Checker for esr_port, bound in the bench.
   Assumes one core_clk domain with rst_b as synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module esr_checker #(
	parameter WC_CYCLES = 600
) (
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic        ce,
	input wire logic        wp_in,
	input wire logic        sda_out,
	input wire logic        sda_oe_b,
	input wire logic [15:0] rd_addr,
	input wire logic        wr_commit,
	input wire logic        wr_abort,
	input wire logic        wr_busy,
	input wire logic        por_busy
);
	logic [31:0] bc;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// Busy length counter; frozen cycles do not count, as in the timer
	always @(posedge core_clk) bc <= (!rst_b || !wr_busy) ? 32'h0 : bc + {31'h0, ce};
	property p_por_block; wr_commit |-> !por_busy; endproperty
	a_por_block: assert property (p_por_block) else $error("commit during power-on");
	property p_wp; wr_commit |-> !$past(wp_in, 6); endproperty
	a_wp: assert property (p_wp) else $error("commit with protect high");
	property p_busy_nocommit; wr_busy |-> !wr_commit; endproperty
	a_busy_nocommit: assert property (p_busy_nocommit) else $error("commit while busy");
	property p_busy_nack; wr_busy |-> sda_oe_b; endproperty
	a_busy_nack: assert property (p_busy_nack) else $error("data pulled while busy");
	property p_commit_busy; wr_commit |=> wr_busy; endproperty
	a_commit_busy: assert property (p_commit_busy) else $error("no busy after commit");
	property p_busy_len; $fell(wr_busy) |-> bc == WC_CYCLES; endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
	property p_excl; wr_commit |-> !wr_abort ##1 !wr_commit; endproperty
	a_excl: assert property (p_excl) else $error("commit and abort clash");
	property p_reset; $rose(rst_b) |-> rd_addr == 16'h0000 && por_busy; endproperty
	a_reset: assert property (p_reset) else $error("bad state after reset");
	property p_open_drain; sda_out == 1'b0; endproperty
	a_open_drain: assert property (p_open_drain) else $error("data driven high");
endmodule
`default_nettype wire

/* tb/esr_ctl_model.sv */
/* Bus controller model: 800 ns serial clock, data by release or pull.
   Assumes the bench joins the data line with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module esr_ctl_model (
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	logic gl;
	// Clock driven high and data released to the pull-up from power-up
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		gl = 1'b0;
	end
	task automatic hc(input int n);
		repeat (n) @(posedge clk) #5;
	endtask
	task bit_x(input logic b, output logic r);
		// Long low phase: the device answers late through its filters
		hc(1);
		sda_low = !b; // Release only, never drive high
		hc(1);
		scl = gl; // Optional 100 ns spike while low
		hc(1);
		scl = 1'b0;
		hc(3);
		scl = 1'b1;
		hc(2);
		r = sda;
		scl = 1'b0;
	endtask
	task start();
		// Wait for a trailing acknowledge to be released first
		hc(1);
		sda_low = 1'b0;
		hc(5);
		scl = 1'b1;
		hc(2);
		sda_low = 1'b1; // Fall with clock high
		hc(2);
		scl = 1'b0;
	endtask
	task stop();
		hc(1);
		sda_low = 1'b1;
		hc(3);
		scl = 1'b1;
		hc(4);
		sda_low = 1'b0;
		hc(4);
	endtask
	task tx(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, ack);
	endtask
	task rx(output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
		bit_x(1'b1, r);
	endtask
	// Start, nine released clocks, start
	task soft_reset();
		logic r;
		start();
		repeat (9) bit_x(1'b1, r);
		start();
	endtask
endmodule
`default_nettype wire

/* tb/esr_port_bench.sv */
/* Bench for esr_port: controller model on the pins, array as a pattern.
   Assumes a short write cycle. */
`timescale 1ns/1ps
`default_nettype none
module esr_port_bench;
	localparam WC = 600;
	localparam logic [7:0] DW = {4'ha, 3'h5, 1'b0};
	logic core_clk, rst_b, wp_in, supply_low_in, sda_out, sda_oe_b, wdat_valid;
	logic wr_commit, wr_abort, wr_busy, por_busy, ce;
	logic [2:0] strap;
	logic [15:0] rd_addr, wdat_addr, la;
	logic [7:0] wdat, lw, d;
	logic [3:0] k;
	wire logic scl_in, sda_low, sda_in;
	wire logic [7:0] rd_data = rd_addr[7:0] ^ 8'h5a;
	int errors, comparisons, ncom, nab;
	// Pull-up where nobody pulls low
	assign sda_in = !sda_low && (sda_oe_b || sda_out);
	esr_ctl_model ctl (.clk(core_clk), .sda(sda_in), .scl(scl_in), .sda_low(sda_low));
	esr_port #(.WC_CYCLES(WC)) esr_port_inst (.core_clk(core_clk), .rst_b(rst_b), .ce(ce),
		.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_b(sda_oe_b),
		.strap_in(strap), .wp_in(wp_in), .supply_low_in(supply_low_in), .rd_addr(rd_addr),
		.rd_data(rd_data), .wdat_valid(wdat_valid), .wdat_addr(wdat_addr), .wdat(wdat),
		.wr_commit(wr_commit), .wr_abort(wr_abort), .wr_busy(wr_busy), .por_busy(por_busy));
	always @(posedge core_clk) begin
		ncom += (wr_commit === 1'b1);
		nab += (wr_abort === 1'b1);
		if (wdat_valid === 1'b1) {la, lw} <= {wdat_addr, wdat};
	end
	task chk(input string n, input logic [23:0] e, input logic [23:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] v, input logic ok);
		int c, b;
		c = ncom;
		b = nab;
		ctl.start();
		ctl.tx(DW, k[0]);
		ctl.tx(a[15:8], k[1]);
		ctl.tx(a[7:0], k[2]);
		ctl.tx(v, k[3]);
		ctl.stop();
		ctl.hc(10);
		chk("acks", 24'h0, {20'h0, k});
		chk("wdat", {a, v}, {la, lw});
		chk("commit", 24'(ok), 24'(ncom - c));
		chk("abort", 24'(!ok), 24'(nab - b));
	endtask
	task wt();
		for (int i = 0; i < 2000 && (por_busy | wr_busy) !== 1'b0; i++) ctl.hc(1);
		chk("idle", 24'h0, {22'h0, por_busy, wr_busy});
	endtask
	task t_por();
		chk("addr", 24'h0, {8'h0, rd_addr});
		chk("por", 24'h1, {23'h0, por_busy});
		wr(16'h0012, 8'h3c, 1'b0);
		$display("test por done");
	endtask
	task t_busy();
		wr(16'h0012, 8'h3c, 1'b1);
		ctl.start();
		ctl.tx(DW, k[0]);
		ctl.soft_reset();
		ctl.tx(DW, k[1]);
		ctl.stop();
		chk("busy nacks", 24'h3, {22'h0, k[1:0]});
		wt();
		ctl.start();
		ctl.tx(DW, k[0]);
		ctl.stop();
		chk("ack after busy", 24'h0, {23'h0, k[0]});
		$display("test busy done");
	endtask
	task t_block();
		wp_in = 1'b1; // Held from start through stop
		wr(16'h0020, 8'h11, 1'b0);
		wp_in = 1'b0;
		fork
			wr(16'h0021, 8'h22, 1'b0);
			begin
				ctl.hc(150);
				wp_in = 1'b1;
				ctl.hc(4);
				wp_in = 1'b0;
			end
		join
		supply_low_in = 1'b1;
		wr(16'h0022, 8'h33, 1'b0);
		supply_low_in = 1'b0;
		$display("test block done");
	endtask
	task t_srst();
		wp_in = 1'b1;
		ctl.start();
		ctl.tx(DW, k[0]);
		ctl.tx(8'h00, k[0]);
		ctl.soft_reset();
		ctl.tx(DW, k[0]);
		ctl.tx(8'h00, k[1]);
		ctl.tx(8'h40, k[2]);
		ctl.start();
		ctl.tx(DW | 8'h01, k[3]);
		ctl.rx(d);
		ctl.stop();
		wp_in = 1'b0;
		chk("acks", 24'h0, {20'h0, k});
		chk("read", 24'h1a, {16'h0, d});
		$display("test reset done");
	endtask
	task t_glitch();
		ctl.gl = 1'b1;
		wr(16'h0100, 8'ha5, 1'b1);
		ctl.gl = 1'b0;
		wt();
		$display("test glitch done");
	endtask
	task t_strap();
		strap = 3'h4;
		ctl.start();
		ctl.tx(DW, k[0]);
		ctl.stop();
		strap = 3'h5;
		chk("strap nack", 24'h1, {23'h0, k[0]});
		$display("test strap done");
	endtask
	task t_freeze();
		wr(16'h0200, 8'h5e, 1'b1);
		ce = 1'b0;
		ctl.hc(700);
		chk("frozen busy", 24'h1, {23'h0, wr_busy});
		ce = 1'b1;
		wt();
		$display("test freeze done");
	endtask
	task final_report();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		rst_b = 1'b0;
		wp_in = 1'b0;
		supply_low_in = 1'b0;
		ce = 1'b1;
		strap = 3'h5;
		repeat (3) @(posedge core_clk);
		#5 rst_b = 1'b1;
		t_por();
		wt();
		t_busy();
		t_strap();
		t_block();
		t_srst();
		t_glitch();
		t_freeze();
		final_report();
	end
	initial begin
		#3000000;
		errors++;
		final_report();
	end
endmodule
bind esr_port esr_checker #(.WC_CYCLES(WC_CYCLES)) esr_checker_inst (.core_clk(core_clk),
	.rst_b(rst_b), .ce(ce), .wp_in(wp_in), .sda_out(sda_out), .sda_oe_b(sda_oe_b),
	.rd_addr(rd_addr),
	.wr_commit(wr_commit), .wr_abort(wr_abort), .wr_busy(wr_busy), .por_busy(por_busy));
`default_nettype wire
